// ==== rtl/scs_regs.svh ====
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define SCS_IDX_PCG1       14'h1C02
`define SCS_IDX_PCG2       14'h1C03
`define SCS_IDX_RST_LOAD   14'h1C04
`define SCS_IDX_RST_CTRL   14'h1C05
`define SCS_IDX_IDLE       14'h0001
`define SCS_IDX_PLL        14'h1C20
`define SCS_IDX_USB_CTRL   14'h1C32
`define SCS_IDX_BOOT       14'h1C34
`define SCS_IDX_RTC_LO     14'h1900
`define SCS_IDX_RTC_HI     14'h197F
`define SCS_IDX_RTC_PMGT   14'h1930

// ****************************************************************
// fields, reset values, counts
// ****************************************************************
`define SCS_USB_OSC_OFF    5
`define SCS_USB_BIAS_OFF   4
`define SCS_USB_OFF_MASK   16'h0030
`define SCS_IDLE_ALL       16'hFFFE
`define SCS_RST_ZERO       16'h0000
`define SCS_PLL_BOOT0      16'h0101
`define SCS_PLL_BOOT1      16'h0102
`define SCS_PLL_BOOT2      16'h0103
`define SCS_PLL_BOOT3      16'h0104
`define SCS_LATCH_LAST     16'h0009
`define SCS_PROBE_LAST     16'h000F

`endif

// ==== rtl/scs_pkg.sv ====
package scs_pkg;

  typedef enum logic [3:0] {
    ST_LATCH  = 4'h1,
    ST_CONFIG = 4'h2,
    ST_PROBE  = 4'h4,
    ST_USER   = 4'h8
  } scs_fsm_type;

  typedef enum logic [3:0] {
    RG_NONE   = 4'h0,
    RG_PCG1   = 4'h1,
    RG_PCG2   = 4'h2,
    RG_RST_LOAD = 4'h3,
    RG_RST_CTRL = 4'h4,
    RG_IDLE     = 4'h5,
    RG_PLL      = 4'h6,
    RG_USB_CTRL = 4'h7,
    RG_BOOT   = 4'h8,
    RG_RTC    = 4'h9
  } scs_reg_type;

  typedef struct packed {
    logic [7:0] stage1;
    logic [7:0] stage2;
  } scs_sync_state_type;

  typedef struct packed {
    scs_fsm_type  fsm;
    logic [15:0]  cnt;
    logic         clk_sel;
    logic [5:0]   boot_sel;
    logic [15:0]  pcg1;
    logic [15:0]  pcg2;
    logic [15:0]  rst_load;
    logic [15:0]  rst_act;
    logic [15:0]  rst_cnt;
    logic [15:0]  idle_cfg;
    logic [15:0]  pll_cfg;
    logic [15:0]  usb_ctrl;
    logic [15:0]  rtc_pmgt;
    logic         osc_en;
    logic         ref_ext;
    logic         boot_done;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
  } scs_state_type;

endpackage

// ==== rtl/scs_sync.sv ====
`timescale 1ns/10ps
module scs_sync
  import scs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);

  scs_sync_state_type s;
  scs_sync_state_type next_s;

  always_comb begin
    next_s        = s;
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stage2;

endmodule

// ==== rtl/scs_top.sv ====
`timescale 1ns/10ps
`include "scs_regs.svh"
module scs_top
  import scs_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [5:0]  GPIO_BOOT_PINS,
  input  wire logic        CLK_SEL,
  input  wire logic        RTC_OSC_RUN,
  output logic      [31:0] PERIPH_CLK_EN,
  output logic      [15:0] PERIPH_RST,
  output logic      [15:0] IDLE_CFG,
  output logic      [15:0] PLL_CFG,
  output logic             USB_OSC_EN,
  output logic             PLL_REF_EXT,
  output logic      [15:0] RTC_PWR_MGMT,
  output logic             BOOT_DONE
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic scs_reg_type scs_decode(input logic [13:0] idx);
    scs_reg_type r;
    r = RG_NONE;
    case (idx)
      `SCS_IDX_PCG1:     r = RG_PCG1;
      `SCS_IDX_PCG2:     r = RG_PCG2;
      `SCS_IDX_RST_LOAD: r = RG_RST_LOAD;
      `SCS_IDX_RST_CTRL: r = RG_RST_CTRL;
      `SCS_IDX_IDLE:     r = RG_IDLE;
      `SCS_IDX_PLL:      r = RG_PLL;
      `SCS_IDX_USB_CTRL: r = RG_USB_CTRL;
      `SCS_IDX_BOOT:     r = RG_BOOT;
      `SCS_IDX_RTC_PMGT: r = RG_RTC;
      default:           r = RG_NONE;
    endcase
    return r;
  endfunction

  function automatic logic scs_in_rtc(input logic [13:0] idx);
    return (idx >= `SCS_IDX_RTC_LO) && (idx <= `SCS_IDX_RTC_HI);
  endfunction

  function automatic logic [31:0] scs_probe_mask(input logic [5:0] sel);
    logic [31:0] m;
    m = 32'h00000000;
    m[{1'b0, sel[3:0]}] = 1'b1;
    return m;
  endfunction

  function automatic logic [15:0] scs_boot_pll(input logic [5:0] sel);
    logic [15:0] v;
    v = `SCS_PLL_BOOT0;
    case (sel[5:4])
      2'h0:    v = `SCS_PLL_BOOT0;
      2'h1:    v = `SCS_PLL_BOOT1;
      2'h2:    v = `SCS_PLL_BOOT2;
      2'h3:    v = `SCS_PLL_BOOT3;
      default: v = `SCS_PLL_BOOT0;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [7:0]    sync_pins;
  logic [5:0]    boot_pins_s;
  logic          clk_sel_s;
  logic          rtc_run_s;
  scs_state_type s;
  scs_state_type next_s;
  logic [13:0]   idx;
  scs_reg_type   sel;
  logic          blocked;
  logic          bad;
  logic [31:0]   rd;
  logic          wr_go;
  logic [31:0]   probe_mask;

  scs_sync u_sync (
    .clk      (CLK),
    .rst_n    (RST_N),
    .async_in ({RTC_OSC_RUN, CLK_SEL, GPIO_BOOT_PINS}),
    .sync_out (sync_pins)
  );

  assign boot_pins_s = sync_pins[5:0];
  assign clk_sel_s   = sync_pins[6];
  assign rtc_run_s   = sync_pins[7];

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign idx        = PADDR[15:2];
  assign sel        = scs_decode(idx);
  // the whole RTC window goes dark with its oscillator, not just one register
  assign blocked    = scs_in_rtc(idx) && !rtc_run_s;
  assign bad        = (sel == RG_NONE) || blocked;
  assign wr_go      = PSEL && PENABLE && s.pready && PWRITE && !s.pslverr;
  assign probe_mask = scs_probe_mask(s.boot_sel);

  always_comb begin
    rd = 32'h00000000;
    case (sel)
      RG_PCG1:   rd = {16'h0000, s.pcg1};
      RG_PCG2:   rd = {16'h0000, s.pcg2};
      RG_RST_LOAD: rd = {16'h0000, s.rst_load};
      RG_RST_CTRL: rd = {16'h0000, s.rst_act};
      RG_IDLE:     rd = {16'h0000, s.idle_cfg};
      RG_PLL:      rd = {16'h0000, s.pll_cfg};
      RG_USB_CTRL: rd = {16'h0000, s.usb_ctrl};
      RG_BOOT:   rd = {26'h0000000, s.boot_sel};
      RG_RTC:    rd = {16'h0000, s.rtc_pmgt};
      default:   rd = 32'h00000000;
    endcase
    if (blocked) begin
      rd = 32'h00000000;
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;

    // bus answers only after handoff, so software never races the boot steps
    next_s.pready  = PSEL && !s.pready && s.boot_done;
    next_s.pslverr = 1'b0;
    if (PSEL && !s.pready && s.boot_done) begin
      next_s.pslverr = bad;
      next_s.prdata  = bad ? 32'h00000000 : rd;
    end

    if (s.rst_cnt != 16'h0000) begin
      next_s.rst_cnt = s.rst_cnt - 16'h0001;
      if (s.rst_cnt == 16'h0001) begin
        next_s.rst_act = `SCS_RST_ZERO;
      end
    end

    case (s.fsm)
      ST_LATCH: begin
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt == `SCS_LATCH_LAST) begin
          next_s.boot_sel = boot_pins_s;
          next_s.clk_sel  = clk_sel_s;
          // oscillator starts off when the external pin is the source
          next_s.usb_ctrl = clk_sel_s ? `SCS_USB_OFF_MASK : 16'h0000;
          next_s.cnt      = 16'h0000;
          next_s.fsm      = ST_CONFIG;
        end
      end
      ST_CONFIG: begin
        next_s.pll_cfg = scs_boot_pll(s.boot_sel);
        next_s.pcg1    = probe_mask[15:0];
        next_s.pcg2    = probe_mask[31:16];
        next_s.fsm     = ST_PROBE;
      end
      ST_PROBE: begin
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt == `SCS_PROBE_LAST) begin
          next_s.pcg1      = 16'h0000;
          next_s.pcg2      = 16'h0000;
          next_s.idle_cfg  = `SCS_IDLE_ALL;
          next_s.boot_done = 1'b1;
          next_s.cnt       = 16'h0000;
          next_s.fsm       = ST_USER;
        end
      end
      ST_USER: begin
        if (wr_go) begin
          case (sel)
            RG_PCG1:   next_s.pcg1 = PWDATA[15:0];
            RG_PCG2:   next_s.pcg2 = PWDATA[15:0];
            RG_RST_LOAD: next_s.rst_load = PWDATA[15:0];
            RG_RST_CTRL: begin
              // a write during a running pulse adds its bits and restarts the count
              next_s.rst_act = s.rst_act | PWDATA[15:0];
              next_s.rst_cnt = (s.rst_load == 16'h0000) ? 16'h0001 : s.rst_load;
            end
            RG_IDLE:     next_s.idle_cfg = PWDATA[15:0];
            RG_PLL:      next_s.pll_cfg = PWDATA[15:0];
            RG_USB_CTRL: begin
              next_s.usb_ctrl = PWDATA[15:0];
              if (!s.clk_sel) begin
                // oscillator is the system source here, so its off bits stay clear
                next_s.usb_ctrl = PWDATA[15:0] & ~`SCS_USB_OFF_MASK;
              end
            end
            RG_RTC:    next_s.rtc_pmgt = PWDATA[15:0];
            default:   next_s.rtc_pmgt = s.rtc_pmgt;
          endcase
        end
      end
      default: begin
        next_s.fsm = ST_LATCH;
        next_s.cnt = 16'h0000;
      end
    endcase

    // both off bits must be clear for the oscillator to run
    next_s.osc_en  = !next_s.clk_sel ||
                     (!next_s.usb_ctrl[`SCS_USB_OSC_OFF] &&
                      !next_s.usb_ctrl[`SCS_USB_BIAS_OFF]);
    next_s.ref_ext = next_s.clk_sel;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      s           <= '0;
      s.fsm       <= ST_LATCH;
      s.osc_en    <= 1'b1;
      s.rst_act   <= `SCS_RST_ZERO;
    end else begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PRDATA        = s.prdata;
  assign PREADY        = s.pready;
  assign PSLVERR       = s.pslverr;
  assign PERIPH_CLK_EN = {s.pcg2, s.pcg1};
  assign PERIPH_RST    = s.rst_act;
  assign IDLE_CFG      = s.idle_cfg;
  assign PLL_CFG       = s.pll_cfg;
  assign USB_OSC_EN    = s.osc_en;
  assign PLL_REF_EXT   = s.ref_ext;
  assign RTC_PWR_MGMT  = s.rtc_pmgt;
  assign BOOT_DONE     = s.boot_done;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence seq_setup;
    PSEL && !PENABLE && !PREADY && BOOT_DONE;
  endsequence

  sequence seq_write_done(scs_reg_type r);
    PSEL && PENABLE && PREADY && PWRITE && !PSLVERR && sel == r;
  endsequence

  chk_boot_latch: assert property (
    s.fsm == ST_LATCH && s.cnt == `SCS_LATCH_LAST |=> s.boot_sel == $past(boot_pins_s)
  ) else $error("boot selection not latched from pins");

  chk_pll_boot: assert property (
    s.fsm == ST_CONFIG |=> PLL_CFG == scs_boot_pll(s.boot_sel)
  ) else $error("boot clock setup does not follow boot selection");

  chk_gate_write: assert property (
    seq_write_done(RG_PCG2) |=> PERIPH_CLK_EN[31:16] == $past(PWDATA[15:0])
  ) else $error("gating register write did not reach clock enables");

  chk_reset_pulse: assert property (
    (seq_write_done(RG_RST_CTRL) and (s.rst_load == 16'h0003 && PWDATA[15:0] != 16'h0000))
      |=> (PERIPH_RST != 16'h0000) [*3] ##1 PERIPH_RST == 16'h0000
  ) else $error("peripheral reset pulse length wrong");

  chk_probe_clock: assert property (
    s.fsm == ST_PROBE |-> (PERIPH_CLK_EN == scs_probe_mask(s.boot_sel))
  ) else $error("probed peripheral clock not alone during query");

  chk_handoff_state: assert property (
    $rose(BOOT_DONE) |-> PERIPH_CLK_EN == 32'h00000000 && IDLE_CFG == `SCS_IDLE_ALL
  ) else $error("handoff left clocks on or domains awake");

  chk_osc_forced: assert property (
    BOOT_DONE && !s.clk_sel |-> USB_OSC_EN
  ) else $error("oscillator off while it is the system source");

  chk_osc_enable: assert property (
    (seq_write_done(RG_USB_CTRL) and s.clk_sel) |=> USB_OSC_EN ==
      !($past(PWDATA[`SCS_USB_OSC_OFF]) || $past(PWDATA[`SCS_USB_BIAS_OFF]))
  ) else $error("oscillator enable does not follow its two off bits");

  chk_ref_select: assert property (
    BOOT_DONE |-> PLL_REF_EXT == s.clk_sel
  ) else $error("reference source disagrees with latched select pin");

  chk_rtc_blocked: assert property (
    seq_setup and (scs_in_rtc(idx) && !rtc_run_s) |=> PREADY && PSLVERR && PRDATA == 32'h0
  ) else $error("rtc register reachable without rtc oscillator");

  sequence seq_write_refused;
    PSEL && PENABLE && PREADY && PWRITE && PSLVERR;
  endsequence

  sequence seq_probe_last;
    s.fsm == ST_PROBE && s.cnt == `SCS_PROBE_LAST;
  endsequence

  sequence seq_latch_ext;
    s.fsm == ST_LATCH && s.cnt == `SCS_LATCH_LAST && clk_sel_s;
  endsequence

  // a refused write must leave the RTC power and clock gating registers untouched
  chk_write_drop: assert property (
    seq_write_refused |=> $stable(RTC_PWR_MGMT) && $stable(PERIPH_CLK_EN)
  ) else $error("refused write changed a register");

  chk_err_with_ready: assert property (
    PSLVERR |-> PREADY
  ) else $error("error flag raised without ready");

  // software sees no answer at all until the boot steps are over
  chk_ready_held: assert property (
    !BOOT_DONE |-> !PREADY
  ) else $error("bus answered before handoff");

  chk_probe_end: assert property (
    seq_probe_last |=> PERIPH_CLK_EN == 32'h00000000 && BOOT_DONE
  ) else $error("probe clock left on after query");

  chk_osc_boot_off: assert property (
    seq_latch_ext |=> !USB_OSC_EN && PLL_REF_EXT
  ) else $error("oscillator not off at boot with external source");

  chk_usb_bits_clear: assert property (
    BOOT_DONE && !s.clk_sel |-> (s.usb_ctrl & `SCS_USB_OFF_MASK) == 16'h0000
  ) else $error("oscillator off bits set while it is the system source");

  chk_rst_count: assert property (
    PERIPH_RST != 16'h0000 |-> s.rst_cnt != 16'h0000
  ) else $error("peripheral reset held with no count running");

  chk_boot_sel_kept: assert property (
    BOOT_DONE |=> $stable(s.boot_sel)
  ) else $error("boot selection changed after handoff");

endmodule

// ==== testbench/scs_top_bench.sv ====
`timescale 1ns/10ps
module scs_top_bench;
  import scs_pkg::*;

  typedef struct {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
    logic        eexp;
  } scs_row_type;

  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  boot_pins;
  logic        clk_sel;
  logic        rtc_run;
  logic [31:0] clk_en;
  logic [15:0] periph_rst;
  logic [15:0] idle_cfg;
  logic [15:0] pll_cfg;
  logic        osc_en;
  logic        ref_ext;
  logic [15:0] rtc_pmgt;
  logic        boot_done;
  int          n_errors;
  int          cmp_count;
  int          cyc;
  int          hi;
  int          k;
  scs_row_type rows [8];

  scs_top dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .GPIO_BOOT_PINS(boot_pins), .CLK_SEL(clk_sel),
    .RTC_OSC_RUN(rtc_run), .PERIPH_CLK_EN(clk_en), .PERIPH_RST(periph_rst),
    .IDLE_CFG(idle_cfg), .PLL_CFG(pll_cfg), .USB_OSC_EN(osc_en),
    .PLL_REF_EXT(ref_ext), .RTC_PWR_MGMT(rtc_pmgt), .BOOT_DONE(boot_done)
  );

  // ****************************************************************
  // clock, timeout, helpers
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_errors++;
      summarize();
    end
  end

  task summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one idle edge after each transfer keeps psel from being driven twice per step
  task acc(input logic w, input logic [15:0] a, input logic [31:0] d,
           input logic [31:0] rx, input logic ex, input string nm);
    logic [31:0] r;
    logic        e;
    logic        rdy;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // the slave sets the pace; only the bench timeout ends a stuck wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdy = pready;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    chk({nm, " ready"}, 32'h1, {31'h0, rdy});
    chk({nm, " err"}, {31'h0, ex}, {31'h0, e});
    if (!w)
      chk(nm, rx, r);
  endtask

  task do_reset(input logic cs, input logic [5:0] pins);
    rst_n <= 1'b0;
    clk_sel <= cs;
    boot_pins <= pins;
    repeat (5) @(posedge clk);
    chk("rst clk_en", 32'h0, clk_en);
    chk("rst osc_en", 32'h1, {31'h0, osc_en});
    chk("rst misc", 32'h0, {pready, ref_ext, boot_done, periph_rst});
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    boot_pins = 6'h00;
    clk_sel = 1'b0;
    rtc_run = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    cyc = 0;
    rows[0] = '{16'h7008, 32'hFFFF_1234, 32'h0000_1234, 1'b0};
    rows[1] = '{16'h700C, 32'h0000_A5A5, 32'h0000_A5A5, 1'b0};
    rows[2] = '{16'h0004, 32'h0000_0001, 32'h0000_0001, 1'b0};
    rows[3] = '{16'h7080, 32'h0000_0203, 32'h0000_0203, 1'b0};
    rows[4] = '{16'h7010, 32'h0000_0003, 32'h0000_0003, 1'b0};
    rows[5] = '{16'h70C8, 32'h0000_0030, 32'h0000_0000, 1'b0};
    rows[6] = '{16'h70D0, 32'h0000_FFFF, 32'h0000_0015, 1'b0};
    rows[7] = '{16'h0100, 32'h0000_5555, 32'h0000_0000, 1'b1};
    @(posedge clk);
    do_reset(1'b0, 6'h15);
    k = 0;
    while (clk_en === 32'h0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    chk("probe clock", 32'h0000_0020, clk_en);
    k = 0;
    while (boot_done !== 1'b1 && k < 60) begin
      @(posedge clk);
      k++;
    end
    chk("handoff clocks", 32'h0, clk_en);
    chk("handoff idle", 32'hFFFE, {16'h0, idle_cfg});
    chk("boot pll", 32'h0102, {16'h0, pll_cfg});
    chk("ref internal", 32'h3, {30'h0, osc_en, ~ref_ext});
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, rows[i].addr, rows[i].wdata, 32'h0, rows[i].eexp, "row wr");
      acc(1'b0, rows[i].addr, 32'h0, rows[i].rexp, rows[i].eexp, "row rd");
    end
    chk("gates", 32'hA5A5_1234, clk_en);
    chk("idle cfg", 32'h0001, {16'h0, idle_cfg});
    chk("pll cfg", 32'h0203, {16'h0, pll_cfg});
    chk("osc locked on", 32'h1, {31'h0, osc_en});

    // ****************************************************************
    // awkward cases
    // ****************************************************************
    hi = 0;
    fork
      acc(1'b1, 16'h7014, 32'h0000_0011, 32'h0, 1'b0, "rst ctl wr");
      repeat (12) begin
        @(posedge clk);
        if (periph_rst === 16'h0011)
          hi++;
      end
    join
    chk("reset pulse len", 32'd3, hi);
    chk("reset pulse end", 32'h0, {16'h0, periph_rst});
    acc(1'b1, 16'h64C0, 32'h0000_00A5, 32'h0, 1'b1, "rtc off wr");
    acc(1'b0, 16'h64C0, 32'h0, 32'h0, 1'b1, "rtc off rd");
    chk("rtc kept", 32'h0, {16'h0, rtc_pmgt});
    rtc_run <= 1'b1;
    repeat (4) @(posedge clk);
    acc(1'b1, 16'h64C0, 32'h0000_00A5, 32'h0, 1'b0, "rtc on wr");
    chk("rtc written", 32'h00A5, {16'h0, rtc_pmgt});

    // second reset: external reference; early read is held until boot ends
    do_reset(1'b1, 6'h32);
    acc(1'b0, 16'h70D0, 32'h0, 32'h0000_0032, 1'b0, "early boot rd");
    chk("ext pll", 32'h0104, {16'h0, pll_cfg});
    chk("ext ref", 32'h1, {31'h0, ref_ext});
    chk("osc starts off", 32'h0, {31'h0, osc_en});
    acc(1'b0, 16'h70C8, 32'h0, 32'h0000_0030, 1'b0, "usb rd");
    acc(1'b1, 16'h70C8, 32'h0000_0010, 32'h0, 1'b0, "usb wr");
    chk("bias only", 32'h0, {31'h0, osc_en});
    acc(1'b1, 16'h70C8, 32'h0000_0000, 32'h0, 1'b0, "usb wr");
    chk("osc enabled", 32'h1, {31'h0, osc_en});
    acc(1'b1, 16'h70C8, 32'h0000_0020, 32'h0, 1'b0, "usb wr");
    chk("osc disabled", 32'h0, {31'h0, osc_en});
    summarize();
  end
endmodule
